//--- verilog/system_integration_unit.sv
// Low-power mode control, reset cause logging and break handling with an APB slave.
//
// What this block does
// - Stop mode turns off the clock generator output to core and peripherals.
// - Recovery counter stays cleared in stop, then counts the recovery interval.
// - Stop ends on a module interrupt, a reset or a break request.
// - After interrupt wake from stop, stacking starts only once recovery elapsed.
// - Recovery lasts 4096 internal clocks, or 32 with short recovery selected.
// - Exit request is reset pin low or core interrupt or break.
// - Break status, reset cause and break flag control sit at FE00, FE01, FE03.
// - Break exit flag reads one when a break ended wait mode.
// - Reading the reset cause register clears all its flags.
// - Power-on reset sets the power-on flag and clears all others.
// - Reset flags accumulate; each new reset only adds its own flag.
// - Reset pin driven low during resets, sampled 32 cycles after release.
// - Own flags for pin, watchdog, bad opcode, bad fetch and low voltage.
// - Monitor entry flag set on blank reset vector with interrupt pin normal.
// - Break clear enable is read/write; clearing during break needs it set.
// - Flags cleared during break stay cleared; two-step clears stay protected.
// - A break request forces the core to the software interrupt vector.
`timescale 1ns/10ps

module system_integration_unit #(
    parameter int LONG_RECOVERY = sys_integ_pkg::LONG_RECOVERY_CYCLES,
    parameter int SHORT_RECOVERY = sys_integ_pkg::SHORT_RECOVERY_CYCLES,
    parameter int DRIVE_CYCLES = sys_integ_pkg::RESET_DRIVE_CYCLES
) (
    // Clock and power-on reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sys_integ_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Core handshake.
    input wire logic stopEntry,
    input wire logic waitEntry,
    input wire logic irqRequest,
    input wire logic breakRequest,
    input wire logic breakEnd,
    input wire logic shortRecoverySelect,
    output logic clockGenEnable,
    output logic cpuClockEnable,
    output logic lowPowerExit,
    output logic stackStart,
    output logic swiForce,
    output logic breakState,
    output logic breakClearAllowed,
    // Reset sources.
    input wire logic watchdogReset,
    input wire logic badOpcode,
    input wire logic badFetchAddress,
    input wire logic lowVoltage,
    input wire logic [7:0] resetVectorHigh,
    input wire logic [7:0] resetVectorLow,
    input wire logic irqPinNormal,
    output logic systemReset,
    // Reset pin, open drain.
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOe
);

    localparam int CW = sys_integ_pkg::CNT_W;
    localparam int NE = sys_integ_pkg::NUM_EVENTS;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [7:0] cause;
        logic breakWait;
        logic clearEnable;
        logic [NE-1:0] irqStatus;
        logic [NE-1:0] irqEnable;
        sys_integ_pkg::power_mode_t mode;
        logic [CW-1:0] recCount;
        logic wakeByIrq;
        sys_integ_pkg::reset_phase_t phase;
        logic [CW-1:0] rstCount;
        logic monChecked;
        logic breakPrev;
        logic inBreak;
        logic breakClearAllowed;
        logic swiForce;
        logic stackStart;
        logic lowPowerExit;
        logic clockGenEnable;
        logic cpuClockEnable;
        logic systemReset;
        logic pinOe;
    } state_t;

    state_t s;
    state_t next_s;

    always_comb begin
        logic pinLow;
        logic irqNormal;
        logic setup;
        logic access;
        logic [15:0] widx;
        logic exitNow;
        logic clearOk;
        logic startRst;
        logic setWait;
        logic [7:0] causeSet;
        logic [NE-1:0] ev;
        logic [CW-1:0] recLimit;
        logic [31:0] rd;
        logic mapped;
        pinLow = 1'b0;
        irqNormal = 1'b0;
        setup = 1'b0;
        access = 1'b0;
        widx = '0;
        exitNow = 1'b0;
        clearOk = 1'b0;
        startRst = 1'b0;
        setWait = 1'b0;
        causeSet = '0;
        ev = '0;
        recLimit = '0;
        rd = '0;
        mapped = 1'b0;

        next_s = s;
        next_s.stackStart = 1'b0;
        next_s.swiForce = 1'b0;

        // Both pins are asynchronous to the core clock.
        next_s.sync1 = {irqPinNormal, rstPinIn};
        next_s.sync2 = s.sync1;
        pinLow = ~s.sync2[0];
        irqNormal = s.sync2[1];

        setup = psel & ~penable;
        access = psel & penable & s.pready;
        widx = paddr[sys_integ_pkg::ADDR_W-1:2];
        clearOk = ~s.inBreak | s.clearEnable;

        // Break entry forces the software interrupt vector once per request.
        next_s.breakPrev = breakRequest;
        if (breakEnd) begin
            next_s.inBreak = 1'b0;
        end
        if (breakRequest & ~s.breakPrev) begin
            next_s.inBreak = 1'b1;
            next_s.swiForce = 1'b1;
        end

        exitNow = pinLow | irqRequest | breakRequest;
        next_s.lowPowerExit = exitNow;
        recLimit = shortRecoverySelect ? CW'(SHORT_RECOVERY - 1) : CW'(LONG_RECOVERY - 1);

        case (s.mode)
            sys_integ_pkg::MODE_RUN: begin
                if (stopEntry) begin
                    next_s.mode = sys_integ_pkg::MODE_STOP;
                    next_s.recCount = '0;
                end else if (waitEntry) begin
                    next_s.mode = sys_integ_pkg::MODE_WAIT;
                end
            end
            sys_integ_pkg::MODE_WAIT: begin
                if (exitNow) begin
                    next_s.mode = sys_integ_pkg::MODE_RUN;
                    if (breakRequest) begin
                        setWait = 1'b1;
                        ev[sys_integ_pkg::EV_BREAK_WAKE] = 1'b1;
                    end else if (irqRequest) begin
                        next_s.stackStart = 1'b1;
                    end
                end
            end
            sys_integ_pkg::MODE_STOP: begin
                next_s.recCount = '0;
                if (irqRequest | breakRequest) begin
                    next_s.mode = sys_integ_pkg::MODE_RECOVER;
                    next_s.wakeByIrq = irqRequest & ~breakRequest;
                end
            end
            sys_integ_pkg::MODE_RECOVER: begin
                next_s.recCount = s.recCount + CW'(1);
                if (s.recCount >= recLimit) begin
                    next_s.mode = sys_integ_pkg::MODE_RUN;
                    next_s.stackStart = s.wakeByIrq;
                    ev[sys_integ_pkg::EV_STOP_RECOVERED] = 1'b1;
                end
            end
            default: begin
                next_s.mode = sys_integ_pkg::MODE_RUN;
            end
        endcase

        // Internal reset sources log their own flag and restart the pin drive.
        causeSet[sys_integ_pkg::BIT_WATCHDOG] = watchdogReset;
        causeSet[sys_integ_pkg::BIT_BAD_OPCODE] = badOpcode;
        causeSet[sys_integ_pkg::BIT_BAD_FETCH] = badFetchAddress;
        causeSet[sys_integ_pkg::BIT_LOW_VOLTAGE] = lowVoltage;
        startRst = watchdogReset | badOpcode | badFetchAddress | lowVoltage;

        case (s.phase)
            sys_integ_pkg::PH_DRIVE: begin
                next_s.rstCount = s.rstCount + CW'(1);
                if (s.rstCount >= CW'(DRIVE_CYCLES - 1)) begin
                    next_s.phase = sys_integ_pkg::PH_SETTLE;
                    next_s.rstCount = '0;
                    next_s.pinOe = 1'b0;
                end
            end
            sys_integ_pkg::PH_SETTLE: begin
                next_s.rstCount = s.rstCount + CW'(1);
                if (s.rstCount >= CW'(sys_integ_pkg::PIN_SAMPLE_CYCLES - 1)) begin
                    next_s.phase = sys_integ_pkg::PH_IDLE;
                    causeSet[sys_integ_pkg::BIT_PIN] = pinLow;
                end
            end
            sys_integ_pkg::PH_IDLE: begin
                if (pinLow) begin
                    causeSet[sys_integ_pkg::BIT_PIN] = 1'b1;
                    startRst = 1'b1;
                end
                if (~s.monChecked) begin
                    next_s.monChecked = 1'b1;
                    if (resetVectorHigh == sys_integ_pkg::VECTOR_BLANK &&
                        resetVectorLow == sys_integ_pkg::VECTOR_BLANK && irqNormal) begin
                        causeSet[sys_integ_pkg::BIT_MONITOR] = 1'b1;
                        startRst = 1'b1;
                    end
                end
            end
            default: begin
                next_s.phase = sys_integ_pkg::PH_IDLE;
            end
        endcase

        if (startRst) begin
            next_s.phase = sys_integ_pkg::PH_DRIVE;
            next_s.rstCount = '0;
            next_s.pinOe = 1'b1;
            ev[sys_integ_pkg::EV_RESET_LOGGED] = 1'b1;
        end
        if (next_s.phase != sys_integ_pkg::PH_IDLE) begin
            // A reset always lands the core back in run mode.
            next_s.mode = sys_integ_pkg::MODE_RUN;
        end
        next_s.systemReset = next_s.phase != sys_integ_pkg::PH_IDLE;
        next_s.clockGenEnable = next_s.mode != sys_integ_pkg::MODE_STOP &&
                                next_s.mode != sys_integ_pkg::MODE_RECOVER;
        next_s.cpuClockEnable = next_s.mode == sys_integ_pkg::MODE_RUN;

        // Register writes and read side effects take place at the access edge.
        if (access & pwrite) begin
            case (widx)
                sys_integ_pkg::IDX_BREAK_STATUS: begin
                    if (~pwdata[sys_integ_pkg::BIT_BREAK_EXIT_WAIT] & clearOk) begin
                        next_s.breakWait = 1'b0;
                    end
                end
                sys_integ_pkg::IDX_BREAK_FLAG_CONTROL: begin
                    next_s.clearEnable = pwdata[sys_integ_pkg::BIT_CLEAR_ENABLE];
                end
                sys_integ_pkg::IDX_IRQ_ENABLE: begin
                    next_s.irqEnable = pwdata[NE-1:0];
                end
                sys_integ_pkg::IDX_IRQ_CLEAR: begin
                    next_s.irqStatus = s.irqStatus & ~pwdata[NE-1:0];
                end
                default: begin
                end
            endcase
        end
        if (access & ~pwrite & widx == sys_integ_pkg::IDX_RESET_CAUSE & clearOk) begin
            next_s.cause = '0;
        end
        // Events set after the clears so that a coincident set wins.
        next_s.cause = next_s.cause | causeSet;
        if (setWait) begin
            next_s.breakWait = 1'b1;
        end
        next_s.irqStatus = next_s.irqStatus | ev;
        next_s.irq = |(next_s.irqStatus & next_s.irqEnable);
        next_s.breakClearAllowed = ~next_s.inBreak | next_s.clearEnable;

        // Read data is captured in the setup cycle so that it leaves a flop.
        mapped = 1'b1;
        case (widx)
            sys_integ_pkg::IDX_BREAK_STATUS: begin
                rd[sys_integ_pkg::BIT_BREAK_EXIT_WAIT] = s.breakWait;
            end
            sys_integ_pkg::IDX_RESET_CAUSE: begin
                rd[7:0] = s.cause;
            end
            sys_integ_pkg::IDX_BREAK_FLAG_CONTROL: begin
                rd[sys_integ_pkg::BIT_CLEAR_ENABLE] = s.clearEnable;
            end
            sys_integ_pkg::IDX_IRQ_STATUS: begin
                rd[NE-1:0] = s.irqStatus;
            end
            sys_integ_pkg::IDX_IRQ_ENABLE: begin
                rd[NE-1:0] = s.irqEnable;
            end
            sys_integ_pkg::IDX_IRQ_CLEAR: begin
                rd = '0;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        next_s.pready = setup;
        if (setup) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd;
            next_s.pslverr = ~mapped;
        end else begin
            next_s.pslverr = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.sync1 <= 2'b11;
            s.sync2 <= 2'b11;
            s.cause <= sys_integ_pkg::CAUSE_AFTER_POR;
            s.mode <= sys_integ_pkg::MODE_RUN;
            s.phase <= sys_integ_pkg::PH_DRIVE;
            s.pinOe <= 1'b1;
            s.systemReset <= 1'b1;
            s.clockGenEnable <= 1'b1;
            s.cpuClockEnable <= 1'b1;
            s.breakClearAllowed <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign clockGenEnable = s.clockGenEnable;
    assign cpuClockEnable = s.cpuClockEnable;
    assign lowPowerExit = s.lowPowerExit;
    assign stackStart = s.stackStart;
    assign swiForce = s.swiForce;
    assign breakState = s.inBreak;
    assign breakClearAllowed = s.breakClearAllowed;
    assign systemReset = s.systemReset;
    // The pin is open drain: it only ever pulls low.
    assign rstPinOut = 1'b0;
    assign rstPinOe = s.pinOe;

endmodule

//--- verilog/sys_integ_pkg.sv
// Shared constants and state encodings of the system integration unit.
package sys_integ_pkg;

    // Word indices of the registers; the byte address is four times the index.
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_BREAK_STATUS = 16'hFE00;
    localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
    localparam logic [15:0] IDX_BREAK_FLAG_CONTROL = 16'hFE03;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hFE04;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hFE05;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'hFE06;

    // Field positions.
    localparam int BIT_BREAK_EXIT_WAIT = 1;
    localparam int BIT_POR = 7;
    localparam int BIT_PIN = 6;
    localparam int BIT_WATCHDOG = 5;
    localparam int BIT_BAD_OPCODE = 4;
    localparam int BIT_BAD_FETCH = 3;
    localparam int BIT_MONITOR = 2;
    localparam int BIT_LOW_VOLTAGE = 1;
    localparam int BIT_CLEAR_ENABLE = 7;

    // Interrupt events.
    localparam int NUM_EVENTS = 3;
    localparam int EV_STOP_RECOVERED = 0;
    localparam int EV_BREAK_WAKE = 1;
    localparam int EV_RESET_LOGGED = 2;

    // Reset values and patterns.
    localparam logic [7:0] CAUSE_AFTER_POR = 8'h80;
    localparam logic [7:0] VECTOR_BLANK = 8'hFF;

    // Cycle counts.
    localparam int LONG_RECOVERY_CYCLES = 4096;
    localparam int SHORT_RECOVERY_CYCLES = 32;
    localparam int PIN_SAMPLE_CYCLES = 32;
    localparam int RESET_DRIVE_CYCLES = 32;
    localparam int CNT_W = 13;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_STOP = 2'b01,
        MODE_RECOVER = 2'b11,
        MODE_WAIT = 2'b10
    } power_mode_t;

    typedef enum logic [1:0] {
        PH_DRIVE = 2'b00,
        PH_SETTLE = 2'b01,
        PH_IDLE = 2'b11
    } reset_phase_t;

endpackage

//--- test/sys_integ_props.sv
// Port-level assertions for the system integration unit.
`timescale 1ns/10ps
module sys_integ_props (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Core side.
    input wire logic stopEntry,
    input wire logic irqRequest,
    input wire logic breakRequest,
    input wire logic clockGenEnable,
    input wire logic cpuClockEnable,
    input wire logic lowPowerExit,
    input wire logic swiForce,
    input wire logic breakState,
    // Reset pin.
    input wire logic watchdogReset,
    input wire logic systemReset,
    input wire logic rstPinOut,
    input wire logic rstPinOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    stop_gate_a: assert property (stopEntry && cpuClockEnable && !systemReset |=> !clockGenEnable)
        else $error("clock output still on after stop entry");
    exit_request_a: assert property (irqRequest || breakRequest |=> lowPowerExit)
        else $error("exit request missing");
    swi_pulse_a: assert property ($rose(breakRequest) |=> swiForce ##1 !swiForce)
        else $error("software interrupt force not one pulse");
    break_entry_a: assert property (swiForce |-> breakState)
        else $error("break state not set with forced vector");
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("bus access not answered");
    slave_error_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error response outside access phase");
    pin_drive_a: assert property (watchdogReset |-> ##[1:2] rstPinOe)
        else $error("reset pin not pulled on internal reset");
    pin_level_a: assert property (rstPinOe |-> systemReset && !rstPinOut)
        else $error("reset pin pulled outside a reset or driven high");
endmodule

bind system_integration_unit sys_integ_props u_sys_integ_props (.core_clk, .reset_n, .psel,
    .penable, .pready, .pslverr, .stopEntry, .irqRequest, .breakRequest, .clockGenEnable,
    .cpuClockEnable, .lowPowerExit, .swiForce, .breakState, .watchdogReset, .systemReset,
    .rstPinOut, .rstPinOe);

//--- test/core_pin_model.sv
// Reset pin pull-up and option bit source at the far side of the unit.
`timescale 1ns/10ps
module core_pin_model (
    // Pin side.
    input wire logic rstPinOe,
    input wire logic holdPinLow,
    output logic rstPinIn,
    // Option register.
    input wire logic wantShort,
    output logic shortRecoverySelect
);
    // The pin has a pull-up, so it reads high whenever nobody pulls it low.
    assign rstPinIn = !(rstPinOe || holdPinLow);
    // Short recovery only on request, so crystal boards keep the full delay.
    assign shortRecoverySelect = wantShort;
endmodule

//--- test/system_integration_unit_tb_top.sv
// Self-checking bench for the system integration unit.
`timescale 1ns/10ps
module system_integration_unit_tb_top;
    logic core_clk = 0;
    logic reset_n = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, err;
    logic stopEntry = 0, waitEntry = 0, irqRequest = 0, breakRequest = 0, breakEnd = 0;
    logic watchdogReset = 0, badOpcode = 0, badFetchAddress = 0, lowVoltage = 0;
    logic holdPinLow = 0, wantShort = 0;
    logic [7:0] resetVectorHigh = 8'h12, resetVectorLow = 8'h34;
    logic irqPinNormal = 1'b1;
    logic shortRecoverySelect, clockGenEnable, cpuClockEnable, lowPowerExit, stackStart;
    logic swiForce, breakState, breakClearAllowed, systemReset, rstPinIn, rstPinOut, rstPinOe;
    int errors = 0;
    int n_checks = 0;

    // Short counts keep the run brief; expectations follow these values.
    system_integration_unit #(.LONG_RECOVERY(64), .SHORT_RECOVERY(8), .DRIVE_CYCLES(4))
        u_system_integration_unit (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .stopEntry, .waitEntry, .irqRequest,
        .breakRequest, .breakEnd, .shortRecoverySelect, .clockGenEnable, .cpuClockEnable,
        .lowPowerExit, .stackStart, .swiForce, .breakState, .breakClearAllowed,
        .watchdogReset, .badOpcode, .badFetchAddress, .lowVoltage,
        .resetVectorHigh, .resetVectorLow, .irqPinNormal,
        .systemReset, .rstPinIn, .rstPinOut, .rstPinOe);
    core_pin_model u_core_pin_model (.rstPinOe, .holdPinLow, .rstPinIn, .wantShort,
        .shortRecoverySelect);

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (3) @(posedge core_clk);
        while (systemReset !== 1'b0 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
        chk("systemReset", 0, systemReset);
        repeat (3) @(posedge core_clk);
        if (n >= 400) end_sim();
    endtask

    task automatic por_and_map();
        wait_idle();
        rdchk("cause power-on", sys_integ_pkg::IDX_RESET_CAUSE, 32'h80);
        rdchk("cause after read", sys_integ_pkg::IDX_RESET_CAUSE, 32'h0);
        apb(1'b0, 16'hFE02, 32'h0);
        chk("unmapped error", 1, err);
        apb(1'b1, sys_integ_pkg::IDX_BREAK_FLAG_CONTROL, 32'hFFFF_FFFF);
        rdchk("flag control", sys_integ_pkg::IDX_BREAK_FLAG_CONTROL, 32'h80);
        apb(1'b1, sys_integ_pkg::IDX_BREAK_FLAG_CONTROL, 32'h0);
        rdchk("break status", sys_integ_pkg::IDX_BREAK_STATUS, 32'h0);
    endtask

    task automatic reset_sources();
        @(posedge core_clk);
        watchdogReset <= 1'b1;
        @(posedge core_clk);
        watchdogReset <= 1'b0;
        repeat (2) @(posedge core_clk);
        badOpcode <= 1'b1;
        @(posedge core_clk);
        badOpcode <= 1'b0;
        wait_idle();
        rdchk("cause two", sys_integ_pkg::IDX_RESET_CAUSE, 32'h30);
        @(posedge core_clk);
        lowVoltage <= 1'b1;
        badFetchAddress <= 1'b1;
        @(posedge core_clk);
        lowVoltage <= 1'b0;
        badFetchAddress <= 1'b0;
        wait_idle();
        rdchk("cause voltage fetch", sys_integ_pkg::IDX_RESET_CAUSE, 32'h0A);
        @(posedge core_clk);
        holdPinLow <= 1'b1;
        repeat (6) @(posedge core_clk);
        holdPinLow <= 1'b0;
        wait_idle();
        rdchk("cause pin", sys_integ_pkg::IDX_RESET_CAUSE, 32'h40);
    endtask

    task automatic stop_wake(input logic sel, input int limit, input logic en);
        int n;
        wantShort <= sel;
        apb(1'b1, sys_integ_pkg::IDX_IRQ_CLEAR, 32'h7);
        apb(1'b1, sys_integ_pkg::IDX_IRQ_ENABLE, {31'h0, en});
        @(posedge core_clk);
        stopEntry <= 1'b1;
        @(posedge core_clk);
        stopEntry <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("clock output in stop", 0, clockGenEnable);
        chk("core clock in stop", 0, cpuClockEnable);
        irqRequest <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (clockGenEnable !== 1'b1 && n < 5000);
        // One edge to wake, the limit in recovery, then one edge until the bench sees run.
        chk("recovery cycles", limit + 2, n);
        if (n >= 5000) end_sim();
        chk("stacking at run", 1, stackStart);
        irqRequest <= 1'b0;
        rdchk("event status", sys_integ_pkg::IDX_IRQ_STATUS, 32'h1);
        chk("irq line", {31'h0, en}, irq);
        apb(1'b1, sys_integ_pkg::IDX_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("irq after clear", 0, irq);
    endtask

    task automatic break_wait();
        @(posedge core_clk);
        waitEntry <= 1'b1;
        @(posedge core_clk);
        waitEntry <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("core clock in wait", 0, cpuClockEnable);
        breakRequest <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("break state", 1, breakState);
        chk("exit request", 1, lowPowerExit);
        chk("core clock after break", 1, cpuClockEnable);
        chk("clear allowed", 0, breakClearAllowed);
        rdchk("wait exit flag", sys_integ_pkg::IDX_BREAK_STATUS, 32'h2);
        apb(1'b1, sys_integ_pkg::IDX_BREAK_STATUS, 32'h0);
        rdchk("protected flag", sys_integ_pkg::IDX_BREAK_STATUS, 32'h2);
        apb(1'b1, sys_integ_pkg::IDX_BREAK_FLAG_CONTROL, 32'h80);
        apb(1'b1, sys_integ_pkg::IDX_BREAK_STATUS, 32'h0);
        breakRequest <= 1'b0;
        rdchk("cleared in break", sys_integ_pkg::IDX_BREAK_STATUS, 32'h0);
        breakEnd <= 1'b1;
        @(posedge core_clk);
        breakEnd <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("break left", 0, breakState);
        rdchk("cleared after break", sys_integ_pkg::IDX_BREAK_STATUS, 32'h0);
    endtask

    // A blank reset vector after power-on adds a second reset that logs monitor entry.
    task automatic monitor_entry();
        @(posedge core_clk);
        resetVectorHigh <= 8'hFF;
        resetVectorLow <= 8'hFF;
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_idle();
        wait_idle();
        rdchk("cause monitor", sys_integ_pkg::IDX_RESET_CAUSE, 32'h84);
        rdchk("cause monitor read", sys_integ_pkg::IDX_RESET_CAUSE, 32'h0);
    endtask

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        por_and_map();
        reset_sources();
        stop_wake(1'b0, 64, 1'b1);
        stop_wake(1'b1, 8, 1'b0);
        break_wait();
        monitor_entry();
        end_sim();
    end
endmodule
